// [shared/idc_pkg.sv]
// constants and types shared by the input diagnostic configuration block
package idc_pkg;

  // register offsets on the plain register port
  localparam logic [7:0] ADDR_CELL_TEST = 8'h6C; // cell_test_config
  localparam logic [7:0] ADDR_AUX_TEST = 8'h6D; // aux_test_config
  localparam logic [7:0] ADDR_GEN_DIAG = 8'h6E; // general_diag_config
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h80; // sticky events, read clears
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h81; // interrupt enables
  localparam logic [7:0] ADDR_FAULT_ALERT = 8'h82; // fault_alert_second, read clears
  localparam logic [7:0] ADDR_TEST_RESULT = 8'h83; // first_test_result

  // widths
  localparam int NUM_CELLS = 15; // cell inputs with sources
  localparam int NUM_AUX = 6; // auxiliary inputs
  localparam int LEVEL_W = 4; // shared source level setting
  localparam int BIST_W = 4; // self-test alert bits
  localparam int IRQ_W = 4; // interrupt events
  localparam int MODE_W = 4; // diagnostic mode code width

  // field positions
  localparam int OPEN_SEL_BIT = 15; // cell_open_wire_select
  localparam int CELL_EN_LSB = 0; // cell_source_enable low bit
  localparam int AUX_EN_LO_LSB = 0; // aux_source_enable[3:0]
  localparam int AUX_EN_HI_LSB = 4; // aux_source_enable[5:4]
  localparam int AUX_MODE_LSB = 13; // aux_test_mode_select low bit

  // interrupt status bits
  localparam int IRQ_OPEN_ENTER = 0; // open-wire mode switched on
  localparam int IRQ_AUX_RSVD = 1; // reserved aux mode written
  localparam int IRQ_BIST_FAIL = 2; // a self-test reported fail
  localparam int IRQ_DETAIL = 3; // detailed result captured

  // reset values
  localparam logic [15:0] RST_CELL_TEST = 16'h0000;
  localparam logic [15:0] RST_AUX_TEST = 16'h0000;
  localparam logic [15:0] RST_GEN_DIAG = 16'h0000;
  localparam logic [3:0] RST_IRQ_MASK = 4'h0;

  // aux_test_mode_select codes
  localparam logic [2:0] AUX_CODE_DISCHARGE = 3'h2; // 010
  localparam logic [2:0] AUX_CODE_THERM_GND = 3'h3; // 011

  // decoded auxiliary diagnostic mode
  typedef enum logic [1:0] {
    AUX_NORMAL,
    AUX_DISCHARGE,
    AUX_THERM_GND,
    AUX_RESERVED
  } idc_aux_mode_t;

endpackage

// [rtl/idc_chan_gate.sv]
// per-channel cell selection and source gating
`timescale 1ns/1ps
`default_nettype none

module idc_chan_gate
  import idc_pkg::*;
#(
  parameter int N = NUM_CELLS
) (
  // mode
  input wire logic openWireSel,
  // per-channel controls
  input wire logic [N-1:0] measureMask,
  input wire logic [N-1:0] reverseFlag,
  input wire logic [N-1:0] srcEnable,
  // results
  output logic [N-1:0] chanSel,
  output logic [N-1:0] srcOn
);

  // one identical slice per channel
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gChan
      // normal: mask only; open-wire: mask and not reversed
      assign chanSel[g] = openWireSel ? (measureMask[g] & ~reverseFlag[g]) // see R3
                                      : measureMask[g]; // see R2
      // each bit drives its own source
      assign srcOn[g] = srcEnable[g]; // see R6
    end
  endgenerate

endmodule // idc_chan_gate

`default_nettype wire

// [rtl/idc_top.sv]
// input diagnostic current and mode configuration registers
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: bit 15 selects open-wire test, reset zero
// R2: normal mode measures masked cells, standard thresholds
// R3: open-wire measures masked non-reversed cells, low-side
// R4: host enables pulldowns, comparator-only scan
// R5: host pairs with aux mode 010 or 011
// R6: fifteen cell source enables, reset zero
// R7: all cell sources use shared level
// R8: six aux source enables, shared level/direction
// R9: pin-io mode masks aux enable, readback kept
// R10: three-bit aux mode in top bits
// R11: self-test alerts; detail only when selected
// R12: unused bits read zero, writes ignored
// R13: aux mode decode 00x, 010, 011, reserved
module idc_top
  import idc_pkg::*;
(
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkEn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [15:0] regRdData,
  // acquisition context
  input wire logic [NUM_CELLS-1:0] cellMeasureMask,
  input wire logic [NUM_CELLS-1:0] reverseInputFlag,
  // shared diagnostic settings
  input wire logic [LEVEL_W-1:0] sourceLevelSetting,
  input wire logic sourceDirectionSetting,
  input wire logic [NUM_AUX-1:0] pinIoModeEnable,
  // self-test reports
  input wire logic bistValid,
  input wire logic [1:0] bistIndex,
  input wire logic bistFail,
  input wire logic [MODE_W-1:0] bistMode,
  input wire logic [MODE_W-1:0] resultModeSel,
  input wire logic [15:0] bistDetail,
  // cell path controls
  output logic [NUM_CELLS-1:0] cellChannelSel,
  output logic openWireThresh,
  output logic lowSideOnly,
  output logic adcSeqEnable,
  output logic [NUM_CELLS-1:0] cellSourceOn,
  output logic [LEVEL_W-1:0] cellSourceLevel,
  // aux path controls
  output logic [NUM_AUX-1:0] auxSourceOn,
  output logic [LEVEL_W-1:0] auxSourceLevel,
  output logic auxSourceDir,
  output logic auxDischargeOn,
  output logic thermBiasGround,
  // interrupt
  output logic irq
);

  // decode of aux_test_mode_select, used for outputs and events
  function automatic idc_aux_mode_t decodeAux(input logic [2:0] code);
    idc_aux_mode_t m;
    m = AUX_NORMAL;
    if (code[2]) begin
      m = AUX_RESERVED; // 1xx
    end else if (code == AUX_CODE_DISCHARGE) begin
      m = AUX_DISCHARGE; // 010
    end else if (code == AUX_CODE_THERM_GND) begin
      m = AUX_THERM_GND; // 011
    end
    return m; // 00x stays normal
  endfunction

  // all state of the block
  typedef struct packed {
    logic openSel; // cell_open_wire_select
    logic [NUM_CELLS-1:0] cellSrcEn; // cell_source_enable
    logic [NUM_AUX-1:0] auxSrcEn; // aux_source_enable, as written
    logic [2:0] auxMode; // aux_test_mode_select
    logic [IRQ_W-1:0] irqStatus; // sticky events
    logic [IRQ_W-1:0] irqMask; // event enables
    logic [BIST_W-1:0] faultAlert; // self-test fail alerts
    logic [15:0] testResult; // detailed result
    logic [15:0] rdData; // read answer
    logic [NUM_CELLS-1:0] chanSel; // registered channel select
    logic openThr; // alternate thresholds
    logic lowOnly; // low-side comparator only
    logic adcEn; // adc sequence allowed
    logic [NUM_CELLS-1:0] cellOn; // cell source drive
    logic [LEVEL_W-1:0] cellLvl; // cell source level
    logic [NUM_AUX-1:0] auxOn; // aux source drive
    logic [LEVEL_W-1:0] auxLvl; // aux source level
    logic auxDir; // aux source direction
    logic dischg; // accelerated discharge
    logic thermGnd; // thermistor bias grounded
    logic irqOut; // interrupt line
  } idc_state_t;

  idc_state_t cur_ff; // registered state
  idc_state_t nxt_cur; // next state

  // combinational channel gating
  logic [NUM_CELLS-1:0] gateSel; // selected channels
  logic [NUM_CELLS-1:0] gateSrc; // sources on

  idc_chan_gate #(
    .N(NUM_CELLS)
  ) uGate (
    .openWireSel(cur_ff.openSel),
    .measureMask(cellMeasureMask),
    .reverseFlag(reverseInputFlag),
    .srcEnable(cur_ff.cellSrcEn),
    .chanSel(gateSel),
    .srcOn(gateSrc)
  );

  // decoded strobes
  logic wrCell; // write to cell_test_config
  logic wrAux; // write to aux_test_config
  logic wrGen; // write to general_diag_config
  logic wrMask; // write to mask
  logic rdStatus; // read of status clears it
  logic rdAlert; // read of alerts clears them
  idc_aux_mode_t auxNow; // decode of stored mode
  idc_aux_mode_t auxNew; // decode of written mode

  // address decode
  always_comb begin
    wrCell = regWrStb && (regAddr == ADDR_CELL_TEST);
    wrAux = regWrStb && (regAddr == ADDR_AUX_TEST);
    wrGen = regWrStb && (regAddr == ADDR_GEN_DIAG);
    wrMask = regWrStb && (regAddr == ADDR_IRQ_MASK);
    rdStatus = regRdStb && (regAddr == ADDR_IRQ_STATUS);
    rdAlert = regRdStb && (regAddr == ADDR_FAULT_ALERT);
    auxNow = decodeAux(cur_ff.auxMode);
    auxNew = decodeAux(regWrData[AUX_MODE_LSB +: 3]);
  end

  // next-state logic
  always_comb begin
    logic [IRQ_W-1:0] ev; // events this cycle
    logic [BIST_W-1:0] alertSet; // alert bits to set
    ev = '0;
    alertSet = '0;
    nxt_cur = cur_ff;

    // cell_test_config write; only bits 15:0 exist
    if (wrCell) begin
      nxt_cur.openSel = regWrData[OPEN_SEL_BIT]; // see R1
      nxt_cur.cellSrcEn = regWrData[CELL_EN_LSB +: NUM_CELLS]; // see R6
      // event on entering open-wire diagnosis
      ev[IRQ_OPEN_ENTER] = regWrData[OPEN_SEL_BIT] & ~cur_ff.openSel;
    end

    // aux_test_config write; bits 15:6 dropped
    if (wrAux) begin
      nxt_cur.auxSrcEn[3:0] = regWrData[AUX_EN_LO_LSB +: 4]; // see R8
      nxt_cur.auxSrcEn[5:4] = regWrData[AUX_EN_HI_LSB +: 2]; // see R8, R12
    end

    // general_diag_config write; bits 12:0 dropped
    if (wrGen) begin
      nxt_cur.auxMode = regWrData[AUX_MODE_LSB +: 3]; // see R10, R12
      // flag a reserved code so software notices
      ev[IRQ_AUX_RSVD] = (auxNew == AUX_RESERVED); // see R13
    end

    // mask register
    if (wrMask) begin
      nxt_cur.irqMask = regWrData[IRQ_W-1:0];
    end

    // self-test report: a fail always lands in alerts, whatever the mode
    if (bistValid) begin
      alertSet[bistIndex] = bistFail; // see R11
      ev[IRQ_BIST_FAIL] = bistFail;
      // detail kept only for the selected mode
      if (bistMode == resultModeSel) begin
        nxt_cur.testResult = bistDetail; // see R11
        ev[IRQ_DETAIL] = 1'b1;
      end
    end

    // alert bits: read clears, a new fail wins
    nxt_cur.faultAlert = (rdAlert ? '0 : cur_ff.faultAlert) | alertSet;

    // status bits: read clears, a new event wins
    nxt_cur.irqStatus = (rdStatus ? '0 : cur_ff.irqStatus) | ev;

    // read answer, valid the cycle after the strobe
    if (regRdStb) begin
      case (regAddr)
        ADDR_CELL_TEST: begin
          nxt_cur.rdData = {cur_ff.openSel, cur_ff.cellSrcEn}; // see R1, R6
        end
        ADDR_AUX_TEST: begin
          // value as written, pin-io mode not applied
          nxt_cur.rdData = {10'h000, cur_ff.auxSrcEn}; // see R9, R12
        end
        ADDR_GEN_DIAG: begin
          nxt_cur.rdData = {cur_ff.auxMode, 13'h0000}; // see R10, R12
        end
        ADDR_IRQ_STATUS: begin
          nxt_cur.rdData = {12'h000, cur_ff.irqStatus};
        end
        ADDR_IRQ_MASK: begin
          nxt_cur.rdData = {12'h000, cur_ff.irqMask};
        end
        ADDR_FAULT_ALERT: begin
          nxt_cur.rdData = {12'h000, cur_ff.faultAlert};
        end
        ADDR_TEST_RESULT: begin
          nxt_cur.rdData = cur_ff.testResult;
        end
        default: begin
          nxt_cur.rdData = 16'h0000; // unmapped reads zero
        end
      endcase
    end else begin
      nxt_cur.rdData = 16'h0000; // data only in the answer cycle
    end

    // cell measurement controls
    nxt_cur.chanSel = gateSel; // see R2, R3
    nxt_cur.openThr = cur_ff.openSel; // see R3
    nxt_cur.lowOnly = cur_ff.openSel; // see R3
    nxt_cur.adcEn = ~cur_ff.openSel; // see R2

    // cell sources share one level
    nxt_cur.cellOn = gateSrc;
    nxt_cur.cellLvl = sourceLevelSetting; // see R7

    // aux sources, suppressed in pin-io mode
    nxt_cur.auxOn = cur_ff.auxSrcEn & ~pinIoModeEnable; // see R9
    nxt_cur.auxLvl = sourceLevelSetting; // see R8
    nxt_cur.auxDir = sourceDirectionSetting; // see R8

    // aux diagnostic mode outputs
    case (auxNow)
      AUX_DISCHARGE: begin
        nxt_cur.dischg = 1'b1; // see R13
        nxt_cur.thermGnd = 1'b0;
      end
      AUX_THERM_GND: begin
        nxt_cur.dischg = 1'b0;
        nxt_cur.thermGnd = 1'b1; // see R13
      end
      default: begin
        // normal and reserved codes do nothing
        nxt_cur.dischg = 1'b0;
        nxt_cur.thermGnd = 1'b0;
      end
    endcase

    // level interrupt from next status and mask
    nxt_cur.irqOut = |(nxt_cur.irqStatus & nxt_cur.irqMask);
  end

  // state register with clock enable
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= '0;
      cur_ff.openSel <= RST_CELL_TEST[OPEN_SEL_BIT]; // see R1
      cur_ff.cellSrcEn <= RST_CELL_TEST[NUM_CELLS-1:0]; // see R6
      cur_ff.auxSrcEn <= RST_AUX_TEST[NUM_AUX-1:0];
      cur_ff.auxMode <= RST_GEN_DIAG[AUX_MODE_LSB +: 3]; // see R10
      cur_ff.irqMask <= RST_IRQ_MASK;
      cur_ff.adcEn <= 1'b1;
    end else if (clkEn) begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs straight from flops
  assign regRdData = cur_ff.rdData;
  assign cellChannelSel = cur_ff.chanSel;
  assign openWireThresh = cur_ff.openThr;
  assign lowSideOnly = cur_ff.lowOnly;
  assign adcSeqEnable = cur_ff.adcEn;
  assign cellSourceOn = cur_ff.cellOn;
  assign cellSourceLevel = cur_ff.cellLvl;
  assign auxSourceOn = cur_ff.auxOn;
  assign auxSourceLevel = cur_ff.auxLvl;
  assign auxSourceDir = cur_ff.auxDir;
  assign auxDischargeOn = cur_ff.dischg;
  assign thermBiasGround = cur_ff.thermGnd;
  assign irq = cur_ff.irqOut;

endmodule // idc_top

`default_nettype wire

// [verif/idc_top_props.sv]
// assertion checker for the diagnostic configuration block
`timescale 1ns/1ps
`default_nettype none
module idc_top_props
  import idc_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkEn,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [15:0] regRdData,
  // context and outputs
  input wire logic [NUM_CELLS-1:0] cellMeasureMask,
  input wire logic [NUM_CELLS-1:0] reverseInputFlag,
  input wire logic [LEVEL_W-1:0] sourceLevelSetting,
  input wire logic [NUM_AUX-1:0] pinIoModeEnable,
  input wire logic [NUM_CELLS-1:0] cellChannelSel,
  input wire logic openWireThresh,
  input wire logic lowSideOnly,
  input wire logic adcSeqEnable,
  input wire logic [LEVEL_W-1:0] cellSourceLevel,
  input wire logic [NUM_AUX-1:0] auxSourceOn
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // address hits a known register
  logic mapped;
  assign mapped = regAddr inside {[ADDR_CELL_TEST:ADDR_GEN_DIAG], [ADDR_IRQ_STATUS:ADDR_TEST_RESULT]};
  // write of cell config, then read of it
  sequence s_cell_wr; clkEn && regWrStb && regAddr == ADDR_CELL_TEST; endsequence
  sequence s_cell_rd; clkEn && regRdStb && regAddr == ADDR_CELL_TEST; endsequence
  sequence s_open_wr; s_cell_wr and regWrData[OPEN_SEL_BIT]; endsequence
  chk_rd_idle: assert property (clkEn && !regRdStb |=> regRdData == 16'h0000)
    else $error("read data not zero outside answer");
  chk_rd_unmapped: assert property (clkEn && regRdStb && !mapped |=> regRdData == 16'h0000)
    else $error("unmapped read not zero");
  chk_gen_unused: assert property (clkEn && regRdStb && regAddr == ADDR_GEN_DIAG |=> regRdData[12:0] == 13'h0000)
    else $error("unused general bits not zero");
  chk_cell_readback: assert property (s_cell_wr ##1 s_cell_rd |=> regRdData == $past(regWrData, 2))
    else $error("cell config read-back wrong");
  chk_open_enter: assert property (s_open_wr ##1 clkEn |=> openWireThresh)
    else $error("open-wire select not applied");
  chk_mode_flags: assert property (lowSideOnly == openWireThresh && adcSeqEnable == !openWireThresh)
    else $error("mode flags disagree");
  chk_chan_select: assert property (clkEn |=> cellChannelSel ==
    ($past(cellMeasureMask) & ~({NUM_CELLS{openWireThresh}} & $past(reverseInputFlag))))
    else $error("channel selection wrong");
  chk_aux_gate: assert property (clkEn |=> (auxSourceOn & $past(pinIoModeEnable)) == '0)
    else $error("aux source on in pin mode");
  chk_level_copy: assert property (clkEn |=> cellSourceLevel == $past(sourceLevelSetting))
    else $error("cell level not shared setting");
endmodule // idc_top_props
bind idc_top idc_top_props u_props (.core_clk, .resetn, .clkEn, .regAddr, .regWrData, .regWrStb, .regRdStb,
  .regRdData, .cellMeasureMask, .reverseInputFlag, .sourceLevelSetting, .pinIoModeEnable, .cellChannelSel,
  .openWireThresh, .lowSideOnly, .adcSeqEnable, .cellSourceLevel, .auxSourceOn);
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the diagnostic configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import idc_pkg::*;
;
  // design signals
  logic core_clk, resetn, clkEn, regWrStb, regRdStb, sourceDirectionSetting, bistValid, bistFail;
  logic [7:0] regAddr;
  logic [15:0] regWrData, regRdData, bistDetail, v, d;
  logic [NUM_CELLS-1:0] cellMeasureMask, reverseInputFlag, cellChannelSel, cellSourceOn;
  logic [3:0] sourceLevelSetting, cellSourceLevel, auxSourceLevel, bistMode, resultModeSel;
  logic [NUM_AUX-1:0] pinIoModeEnable, auxSourceOn;
  logic [1:0] bistIndex;
  logic openWireThresh, lowSideOnly, adcSeqEnable, auxSourceDir, auxDischargeOn, thermBiasGround, irq;
  // bench state
  int error_cnt, check_count, i;
  logic [31:0] rnd;
  idc_top uut (.core_clk, .resetn, .clkEn, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
    .cellMeasureMask, .reverseInputFlag, .sourceLevelSetting, .sourceDirectionSetting, .pinIoModeEnable,
    .bistValid, .bistIndex, .bistFail, .bistMode, .resultModeSel, .bistDetail, .cellChannelSel,
    .openWireThresh, .lowSideOnly, .adcSeqEnable, .cellSourceOn, .cellSourceLevel, .auxSourceOn,
    .auxSourceLevel, .auxSourceDir, .auxDischargeOn, .thermBiasGround, .irq);
  // free-running clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // expected read-back after masking unused bits
  function automatic logic [15:0] exp_rb(input logic [7:0] a, input logic [15:0] x);
    case (a)
      ADDR_CELL_TEST: return x;
      ADDR_AUX_TEST: return x & 16'h003F;
      ADDR_GEN_DIAG: return x & 16'hE000;
      default: return 16'h0000;
    endcase
  endfunction
  // random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] x);
    @(posedge core_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= x;
    @(posedge core_clk);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q);
    @(posedge core_clk);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1 q = regRdData;
  endtask
  // write then read at once
  task automatic wr_rd(input logic [7:0] a, input logic [15:0] x, output logic [15:0] q);
    @(posedge core_clk);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= x;
    @(posedge core_clk);
    regWrStb <= 1'b0;
    regRdStb <= 1'b1;
    @(posedge core_clk);
    regRdStb <= 1'b0;
    #1 q = regRdData;
  endtask
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    report_and_stop();
  end
  // main sequence
  initial begin
    {resetn, regWrStb, regRdStb, sourceDirectionSetting, bistValid, bistFail, bistIndex} = '0;
    {regAddr, regWrData, bistDetail, bistMode, resultModeSel} = '0;
    {cellMeasureMask, reverseInputFlag, sourceLevelSetting, pinIoModeEnable} = '0;
    clkEn = 1'b1;
    rnd = 32'h0001_2E3A;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    #1 check(adcSeqEnable, 1'b1);
    for (i = 0; i < 3; i++) begin
      rd(ADDR_CELL_TEST + 8'(i), v);
      check(v, 16'h0000);
    end
    // random read-back, unmapped place included
    for (i = 0; i < 30; i++) begin
      rnd = lfsr(rnd);
      wr_rd(8'h6C + 8'(rnd[17:16]), rnd[15:0], v);
      check(v, exp_rb(8'h6C + 8'(rnd[17:16]), rnd[15:0]));
    end
    // both cell modes under random context
    for (i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      d = {i[0], rnd[14:0]};
      @(posedge core_clk);
      cellMeasureMask <= rnd[30:16];
      reverseInputFlag <= rnd[14:0] ^ rnd[31:17];
      sourceLevelSetting <= rnd[19:16];
      sourceDirectionSetting <= rnd[9];
      pinIoModeEnable <= rnd[27:22];
      wr(ADDR_CELL_TEST, d);
      wr(ADDR_AUX_TEST, ~d);
      settle();
      check(cellChannelSel, d[15] ? cellMeasureMask & ~reverseInputFlag : cellMeasureMask);
      check(cellSourceOn, d[14:0]);
      check({openWireThresh, lowSideOnly, adcSeqEnable}, {d[15], d[15], !d[15]});
      check(cellSourceLevel, sourceLevelSetting);
      check({auxSourceLevel, auxSourceDir}, {sourceLevelSetting, sourceDirectionSetting});
      check(auxSourceOn, 6'(~d[5:0] & ~pinIoModeEnable));
      rd(ADDR_AUX_TEST, v);
      check(v, {10'h000, ~d[5:0]});
    end
    // every aux mode code
    for (i = 0; i < 8; i++) begin
      wr(ADDR_GEN_DIAG, {i[2:0], 13'h1FFF});
      settle();
      check({auxDischargeOn, thermBiasGround}, {i == 2, i == 3});
      rd(ADDR_GEN_DIAG, v);
      check(v, {i[2:0], 13'h0000});
    end
    // host open-wire recipe: pulldowns on measured cells, paired aux mode
    @(posedge core_clk);
    reverseInputFlag <= '0;
    wr(ADDR_CELL_TEST, {1'b1, cellMeasureMask});
    wr(ADDR_GEN_DIAG, {AUX_CODE_DISCHARGE, 13'h0000});
    settle();
    check(cellSourceOn, cellMeasureMask);
    check(cellChannelSel, cellMeasureMask);
    check({openWireThresh, auxDischargeOn, thermBiasGround}, 3'b110);
    // interrupt masked, unmasked, cleared
    wr(ADDR_CELL_TEST, 16'h0000);
    wr(ADDR_IRQ_MASK, 16'h0000);
    rd(ADDR_IRQ_STATUS, v);
    wr(ADDR_CELL_TEST, 16'h8000);
    settle();
    check(irq, 1'b0);
    wr(ADDR_IRQ_MASK, 16'h0001);
    settle();
    check(irq, 1'b1);
    rd(ADDR_IRQ_STATUS, v);
    check(v, 16'h0001);
    settle();
    check(irq, 1'b0);
    // self-test: matching then mismatching mode
    rnd = lfsr(rnd);
    d = rnd[15:0];
    @(posedge core_clk);
    {bistValid, bistIndex, bistFail, bistMode, resultModeSel} <= {1'b1, 2'd2, 1'b1, 4'hA, 4'hA};
    bistDetail <= d;
    @(posedge core_clk);
    {bistIndex, bistFail, bistMode} <= {2'd1, 1'b0, 4'h5};
    bistDetail <= ~d;
    @(posedge core_clk);
    bistValid <= 1'b0;
    rd(ADDR_FAULT_ALERT, v);
    check(v, 16'h0004);
    rd(ADDR_TEST_RESULT, v);
    check(v, d);
    rd(ADDR_IRQ_STATUS, v);
    check(v, 16'h000C);
    rd(ADDR_FAULT_ALERT, v);
    check(v, 16'h0000);
    // clock enable low: a write strobe is not seen
    wr(ADDR_CELL_TEST, 16'h0005);
    clkEn <= 1'b0;
    wr(ADDR_CELL_TEST, 16'h7FFF);
    clkEn <= 1'b1;
    rd(ADDR_CELL_TEST, v);
    check(v, 16'h0005);
    // mid-run reset returns the registers to zero and adcSeqEnable to one
    wr(ADDR_GEN_DIAG, 16'h6000);
    settle();
    check(thermBiasGround, 1'b1);
    @(posedge core_clk);
    resetn <= 1'b0;
    @(posedge core_clk);
    resetn <= 1'b1;
    #1 check({adcSeqEnable, thermBiasGround, openWireThresh}, 3'b100);
    check(cellSourceOn, 16'h0000);
    for (i = 0; i < 3; i++) begin
      rd(ADDR_CELL_TEST + 8'(i), v);
      check(v, 16'h0000);
    end
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
